// ### dcd_decoder.sv
// partial opcode decoder for a 16-bit fixed-point core
// assumes fetch presents one word per valid cycle; second words follow their first word
//
// Behaviour
// - b9xx loads accumulator from zero-extended low byte; zero byte clears it; 1/1.
// - 6a clears low half, loads addressed word to high half; 1/1.
// - 69 clears high half, loads word to low half unextended; 1 cycle.
// - 6b loads accumulator with word shifted by multiplier input amount; 1 cycle.
// - aux load from memory 0000 0sel, short immediate 1011 0sel; 1/2.
// - long aux load bf 0000 1sel plus 16-bit value word; 2/2.
// - page pointer from memory 0d or immediate 1011 110 plus nine bits; 1/2.
// - 0e and 0f load first and second status word from memory; 1/2.
// - nibble 7 multiplier input loads: 3 plain, 0, 2, 1, 4 variants; 1 cycle.
// - accumulate-and-move variant also copies word to next higher address.
// - multiply-accumulate a2, with move a3, plus constant word; 2/3.
// - 8b: 1000 1sel aux pointer, zero byte no-op, else aux modify; 1 cycle.
// - nibble 5 multiplies: 4 signed, 0 add, 1 subtract, 5 unsigned; product kept.
// - be03 shifted product to accumulator; be02 negates accumulator; 1 cycle.
// - a0 normalizes accumulator, address field updates aux register; 1 cycle.
// - bf c plus shift count then constant word, shifted and ORed; 2/2.
// - be82 plus constant ORs constant shifted sixteen into accumulator; 2/2.
`timescale 1ns/1ps
module dcd_decoder (
    input wire logic clk_sys, // core clock, 100 MHz
    input wire logic rstn, // asynchronous reset, active low
    input wire logic instr_valid, // instruction word present
    input wire logic [15:0] instr_word, // word from fetch
    output logic operand_take, // current word consumed as operand
    output logic ctrl_valid, // decoded controls valid, one cycle
    output dcd_pkg::dcd_ctrl_t ctrl, // decoded controls to datapath
    output logic mem_data_move, // copy addressed word to next address
    output logic illegal_op // word outside the decoded subset
);

    // ------------------------------------------------------------------
    // combinational decode of a first word
    // ------------------------------------------------------------------
    dcd_pkg::dcd_ctrl_t dec;
    logic [7:0] ub;
    logic [7:0] lb;
    logic known;

    assign ub = instr_word[15:8];
    assign lb = instr_word[7:0];

    always_comb begin
        dec = '0;
        dec.op = dcd_pkg::DCD_OP_NONE;
        dec.words = dcd_pkg::DCD_WORDS_1;
        dec.cycles = dcd_pkg::DCD_CYC_1;
        dec.indirect = lb[7];
        dec.addr_field = lb[6:0];
        dec.aux_sel = ub[2:0];
        dec.operand = 16'h0000;
        known = 1'b1;
        if (ub == dcd_pkg::DCD_UB_ACC_IMM) begin
            dec.op = dcd_pkg::DCD_OP_ACC_IMM;
            dec.operand = {8'h00, lb};
            dec.indirect = 1'b0;
        end else if (ub == dcd_pkg::DCD_UB_ACC_HIGH) begin
            dec.op = dcd_pkg::DCD_OP_ACC_HIGH;
        end else if (ub == dcd_pkg::DCD_UB_ACC_LOW) begin
            dec.op = dcd_pkg::DCD_OP_ACC_LOW;
        end else if (ub == dcd_pkg::DCD_UB_ACC_TSHIFT) begin
            dec.op = dcd_pkg::DCD_OP_ACC_TSHIFT;
        end else if (ub[7:3] == dcd_pkg::DCD_U5_AUX_MEM) begin
            dec.op = dcd_pkg::DCD_OP_AUX_MEM;
            dec.cycles = dcd_pkg::DCD_CYC_2;
        end else if (ub[7:3] == dcd_pkg::DCD_U5_AUX_SHORT) begin
            dec.op = dcd_pkg::DCD_OP_AUX_SHORT;
            dec.cycles = dcd_pkg::DCD_CYC_2;
            dec.operand = {8'h00, lb};
            dec.indirect = 1'b0;
        end else if (ub == dcd_pkg::DCD_UB_LONG_GRP &&
                     lb[7:3] == dcd_pkg::DCD_LB5_AUX_LONG) begin
            dec.op = dcd_pkg::DCD_OP_AUX_LONG;
            dec.words = dcd_pkg::DCD_WORDS_2;
            dec.cycles = dcd_pkg::DCD_CYC_2;
            dec.aux_sel = lb[2:0];
            dec.indirect = 1'b0;
        end else if (ub == dcd_pkg::DCD_UB_LONG_GRP &&
                     lb[7:4] == dcd_pkg::DCD_N_OR_SHIFT) begin
            dec.op = dcd_pkg::DCD_OP_OR_SHIFT;
            dec.words = dcd_pkg::DCD_WORDS_2;
            dec.cycles = dcd_pkg::DCD_CYC_2;
            dec.shift = lb[3:0];
            dec.indirect = 1'b0;
        end else if (ub == dcd_pkg::DCD_UB_PAGE_MEM) begin
            dec.op = dcd_pkg::DCD_OP_PAGE_MEM;
            dec.cycles = dcd_pkg::DCD_CYC_2;
        end else if (ub[7:1] == dcd_pkg::DCD_U7_PAGE_IMM) begin
            dec.op = dcd_pkg::DCD_OP_PAGE_IMM;
            dec.cycles = dcd_pkg::DCD_CYC_2;
            dec.operand = {7'h00, instr_word[8:0]};
            dec.indirect = 1'b0;
        end else if (ub == dcd_pkg::DCD_UB_STATUS0) begin
            dec.op = dcd_pkg::DCD_OP_STATUS0;
            dec.cycles = dcd_pkg::DCD_CYC_2;
        end else if (ub == dcd_pkg::DCD_UB_STATUS1) begin
            dec.op = dcd_pkg::DCD_OP_STATUS1;
            dec.cycles = dcd_pkg::DCD_CYC_2;
        end else if (ub[7:4] == dcd_pkg::DCD_UN_T_GRP) begin
            case (ub[3:0])
                dcd_pkg::DCD_N_T_LOAD: dec.op = dcd_pkg::DCD_OP_T_LOAD;
                dcd_pkg::DCD_N_T_ACCUM: dec.op = dcd_pkg::DCD_OP_T_ACCUM;
                dcd_pkg::DCD_N_T_MOVE: dec.op = dcd_pkg::DCD_OP_T_MOVE;
                dcd_pkg::DCD_N_T_PRODUCT: dec.op = dcd_pkg::DCD_OP_T_PRODUCT;
                dcd_pkg::DCD_N_T_SUBTRACT: dec.op = dcd_pkg::DCD_OP_T_SUBTRACT;
                default: known = 1'b0;
            endcase
        end else if (ub == dcd_pkg::DCD_UB_MAC || ub == dcd_pkg::DCD_UB_MAC_MOVE) begin
            dec.op = (ub == dcd_pkg::DCD_UB_MAC) ? dcd_pkg::DCD_OP_MAC
                                                 : dcd_pkg::DCD_OP_MAC_MOVE;
            dec.words = dcd_pkg::DCD_WORDS_2;
            dec.cycles = dcd_pkg::DCD_CYC_3;
        end else if (ub == dcd_pkg::DCD_UB_AUX_GRP) begin
            if (lb[7:3] == dcd_pkg::DCD_LB5_AUX_PTR) begin
                dec.op = dcd_pkg::DCD_OP_AUX_PTR;
                dec.aux_sel = lb[2:0];
            end else if (lb == dcd_pkg::DCD_LB_NOP) begin
                dec.op = dcd_pkg::DCD_OP_NOP;
            end else begin
                dec.op = dcd_pkg::DCD_OP_AUX_MODIFY;
            end
        end else if (ub[7:4] == dcd_pkg::DCD_UN_MPY_GRP) begin
            case (ub[3:0])
                dcd_pkg::DCD_N_MPY_SIGNED: dec.op = dcd_pkg::DCD_OP_MPY_SIGNED;
                dcd_pkg::DCD_N_MPY_ADD: dec.op = dcd_pkg::DCD_OP_MPY_ADD;
                dcd_pkg::DCD_N_MPY_SUB: dec.op = dcd_pkg::DCD_OP_MPY_SUB;
                dcd_pkg::DCD_N_MPY_UNS: dec.op = dcd_pkg::DCD_OP_MPY_UNS;
                default: known = 1'b0;
            endcase
        end else if (instr_word == dcd_pkg::DCD_W_PROD_TO_ACC) begin
            dec.op = dcd_pkg::DCD_OP_PROD_TO_ACC;
            dec.indirect = 1'b0;
        end else if (instr_word == dcd_pkg::DCD_W_ACC_NEGATE) begin
            dec.op = dcd_pkg::DCD_OP_ACC_NEGATE;
            dec.indirect = 1'b0;
        end else if (ub == dcd_pkg::DCD_UB_NORMALIZE) begin
            dec.op = dcd_pkg::DCD_OP_NORMALIZE;
        end else if (instr_word == dcd_pkg::DCD_W_OR_HIGH) begin
            dec.op = dcd_pkg::DCD_OP_OR_HIGH;
            dec.words = dcd_pkg::DCD_WORDS_2;
            dec.cycles = dcd_pkg::DCD_CYC_2;
            dec.indirect = 1'b0;
        end else begin
            known = 1'b0;
        end
        if (!known) begin
            dec = '0;
            dec.op = dcd_pkg::DCD_OP_NONE;
        end
    end

    // ------------------------------------------------------------------
    // word sequencing
    // ------------------------------------------------------------------
    dcd_pkg::dcd_state_t state_q;
    dcd_pkg::dcd_ctrl_t held_q;

    assign operand_take = instr_valid && state_q == dcd_pkg::DCD_ST_OPERAND;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= dcd_pkg::DCD_ST_FIRST;
        end else if (instr_valid) begin
            case (state_q)
                dcd_pkg::DCD_ST_FIRST: begin
                    if (dec.words == dcd_pkg::DCD_WORDS_2) begin
                        state_q <= dcd_pkg::DCD_ST_OPERAND;
                    end
                end
                dcd_pkg::DCD_ST_OPERAND: state_q <= dcd_pkg::DCD_ST_FIRST;
                default: state_q <= dcd_pkg::DCD_ST_FIRST;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            held_q <= '0;
        end else if (instr_valid && state_q == dcd_pkg::DCD_ST_FIRST) begin
            held_q <= dec;
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_valid <= 1'b0;
            ctrl <= '0;
            mem_data_move <= 1'b0;
            illegal_op <= 1'b0;
        end else begin
            ctrl_valid <= 1'b0;
            mem_data_move <= 1'b0;
            illegal_op <= 1'b0;
            if (instr_valid && state_q == dcd_pkg::DCD_ST_OPERAND) begin
                ctrl_valid <= 1'b1;
                ctrl <= held_q;
                ctrl.operand <= instr_word;
                if (held_q.op == dcd_pkg::DCD_OP_OR_HIGH) begin
                    ctrl.shift <= 4'h0;
                end
                mem_data_move <= held_q.op == dcd_pkg::DCD_OP_MAC_MOVE;
            end else if (instr_valid && dec.words != dcd_pkg::DCD_WORDS_2) begin
                // unknown words carry zero length and still answer here
                ctrl_valid <= dec.op != dcd_pkg::DCD_OP_NONE;
                ctrl <= dec;
                mem_data_move <= dec.op == dcd_pkg::DCD_OP_T_MOVE;
                illegal_op <= dec.op == dcd_pkg::DCD_OP_NONE;
            end
        end
    end

endmodule

// ### dcd_decoder_props.sv
// concurrent checks on the partial opcode decoder ports
// assumes one clock, async active-low reset, bound to every dcd_decoder
`timescale 1ns/1ps
module dcd_decoder_props (
    input wire logic clk_sys, // core clock
    input wire logic rstn, // async reset, active low
    input wire logic instr_valid, // word present
    input wire logic [15:0] instr_word, // fetched word
    input wire logic operand_take, // word taken as operand
    input wire logic ctrl_valid, // decode pulse
    input wire dcd_pkg::dcd_ctrl_t ctrl, // decoded controls
    input wire logic mem_data_move, // data move pulse
    input wire logic illegal_op // unknown word pulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire logic take1 = instr_valid && !operand_take;
    wire logic [7:0] ub = instr_word[15:8];

    a_acc_imm: assert property (
        take1 && ub == 8'hb9 |=> ctrl_valid && ctrl.op == dcd_pkg::DCD_OP_ACC_IMM
            && ctrl.operand == {8'h00, $past(instr_word[7:0])}) else $error("short load bad");
    a_acc_high: assert property (
        take1 && ub == 8'h6a |=> ctrl_valid && ctrl.op == dcd_pkg::DCD_OP_ACC_HIGH
            && ctrl.words == 2'h1 && ctrl.cycles == 2'h1) else $error("high load bad");
    a_aux_mem: assert property (
        take1 && instr_word[15:11] == 5'h00 |=> ctrl.op == dcd_pkg::DCD_OP_AUX_MEM
            && ctrl.aux_sel == $past(instr_word[10:8]) && ctrl.cycles == 2'h2)
        else $error("aux load bad");
    a_pair_operand: assert property (
        instr_valid && operand_take |=> ctrl_valid && ctrl.words == 2'h2
            && ctrl.operand == $past(instr_word)) else $error("second word bad");
    a_mac_quiet: assert property (
        take1 && instr_word[15:9] == 7'h51 |=> !ctrl_valid && !illegal_op
            && (operand_take || !instr_valid)) else $error("mac answered early");
    a_page_imm: assert property (
        take1 && instr_word[15:9] == 7'h5e |=> ctrl.op == dcd_pkg::DCD_OP_PAGE_IMM
            && ctrl.operand[8:0] == $past(instr_word[8:0]) && ctrl.cycles == 2'h2)
        else $error("page load bad");
    a_move_copy: assert property (
        take1 && ub == 8'h72 |=> mem_data_move && ctrl.op == dcd_pkg::DCD_OP_T_MOVE)
        else $error("move variant bad");
    a_prod_acc: assert property (
        take1 && instr_word == 16'hbe03 |=> ctrl_valid && ctrl.op == dcd_pkg::DCD_OP_PROD_TO_ACC)
        else $error("product copy bad");
    a_acc_normalize_addr: assert property (
        take1 && ub == 8'ha0 |=> ctrl.op == dcd_pkg::DCD_OP_NORMALIZE
            && {ctrl.indirect, ctrl.addr_field} == $past(ub == 8'ha0 ? instr_word[7:0] : 8'h00))
        else $error("normalize bad");
    a_nop_decode: assert property (
        take1 && instr_word == 16'h8b00 |=> ctrl.op == dcd_pkg::DCD_OP_NOP) else $error("nop bad");
endmodule

bind dcd_decoder dcd_decoder_props u_dcd_decoder_props (.clk_sys(clk_sys), .rstn(rstn),
    .instr_valid(instr_valid), .instr_word(instr_word), .operand_take(operand_take),
    .ctrl_valid(ctrl_valid), .ctrl(ctrl), .mem_data_move(mem_data_move), .illegal_op(illegal_op));

// ### dcd_fetch_model.sv
// fetch stage model presenting instruction words to the decoder
// assumes callers enter its tasks just after a rising edge
`timescale 1ns/1ps
module dcd_fetch_model (
    input wire logic clk_sys, // core clock
    output logic instr_valid, // word present
    output logic [15:0] instr_word // word to decoder
);
    initial begin
        instr_valid = 1'b0;
        instr_word = 16'h0000;
    end
    task automatic put(input logic [15:0] w);
        instr_valid <= 1'b1;
        instr_word <= w;
        @(posedge clk_sys);
    endtask
    // idle bus inverts the word each cycle, so the last word returns on every second idle cycle
    task automatic idle(input int n);
        repeat (n) begin
            instr_valid <= 1'b0;
            instr_word <= ~instr_word;
            @(posedge clk_sys);
        end
    endtask
endmodule

// ### dcd_pkg.sv
// package for the partial opcode decoder: opcode patterns, lengths, cycle counts
// assumes 16-bit instruction words from the core fetch stage
package dcd_pkg;

    // ------------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        DCD_OP_NONE        = 5'h00,
        DCD_OP_ACC_IMM     = 5'h01,
        DCD_OP_ACC_HIGH    = 5'h02,
        DCD_OP_ACC_LOW     = 5'h03,
        DCD_OP_ACC_TSHIFT  = 5'h04,
        DCD_OP_AUX_MEM     = 5'h05,
        DCD_OP_AUX_SHORT   = 5'h06,
        DCD_OP_AUX_LONG    = 5'h07,
        DCD_OP_PAGE_MEM    = 5'h08,
        DCD_OP_PAGE_IMM    = 5'h09,
        DCD_OP_STATUS0     = 5'h0a,
        DCD_OP_STATUS1     = 5'h0b,
        DCD_OP_T_LOAD      = 5'h0c,
        DCD_OP_T_ACCUM     = 5'h0d,
        DCD_OP_T_MOVE      = 5'h0e,
        DCD_OP_T_PRODUCT   = 5'h0f,
        DCD_OP_T_SUBTRACT  = 5'h10,
        DCD_OP_MAC         = 5'h11,
        DCD_OP_MAC_MOVE    = 5'h12,
        DCD_OP_AUX_PTR     = 5'h13,
        DCD_OP_NOP         = 5'h14,
        DCD_OP_AUX_MODIFY  = 5'h15,
        DCD_OP_MPY_SIGNED  = 5'h16,
        DCD_OP_MPY_ADD     = 5'h17,
        DCD_OP_MPY_SUB     = 5'h18,
        DCD_OP_MPY_UNS     = 5'h19,
        DCD_OP_PROD_TO_ACC = 5'h1a,
        DCD_OP_ACC_NEGATE  = 5'h1b,
        DCD_OP_NORMALIZE   = 5'h1c,
        DCD_OP_OR_SHIFT    = 5'h1d,
        DCD_OP_OR_HIGH     = 5'h1e
    } dcd_op_t;

    typedef enum logic [0:0] {
        DCD_ST_FIRST   = 1'b0,
        DCD_ST_OPERAND = 1'b1
    } dcd_state_t;

    // ------------------------------------------------------------------
    // opcode patterns
    // ------------------------------------------------------------------
    localparam logic [7:0] DCD_UB_ACC_IMM = 8'hb9;
    localparam logic [7:0] DCD_UB_ACC_HIGH = 8'h6a;
    localparam logic [7:0] DCD_UB_ACC_LOW = 8'h69;
    localparam logic [7:0] DCD_UB_ACC_TSHIFT = 8'h6b;
    localparam logic [4:0] DCD_U5_AUX_MEM = 5'h00;
    localparam logic [4:0] DCD_U5_AUX_SHORT = 5'h16;
    localparam logic [7:0] DCD_UB_LONG_GRP = 8'hbf;
    localparam logic [4:0] DCD_LB5_AUX_LONG = 5'h01;
    localparam logic [7:0] DCD_UB_PAGE_MEM = 8'h0d;
    localparam logic [6:0] DCD_U7_PAGE_IMM = 7'h5e;
    localparam logic [7:0] DCD_UB_STATUS0 = 8'h0e;
    localparam logic [7:0] DCD_UB_STATUS1 = 8'h0f;
    localparam logic [3:0] DCD_UN_T_GRP = 4'h7;
    localparam logic [3:0] DCD_N_T_LOAD = 4'h3;
    localparam logic [3:0] DCD_N_T_ACCUM = 4'h0;
    localparam logic [3:0] DCD_N_T_MOVE = 4'h2;
    localparam logic [3:0] DCD_N_T_PRODUCT = 4'h1;
    localparam logic [3:0] DCD_N_T_SUBTRACT = 4'h4;
    localparam logic [7:0] DCD_UB_MAC = 8'ha2;
    localparam logic [7:0] DCD_UB_MAC_MOVE = 8'ha3;
    localparam logic [7:0] DCD_UB_AUX_GRP = 8'h8b;
    localparam logic [4:0] DCD_LB5_AUX_PTR = 5'h11;
    localparam logic [7:0] DCD_LB_NOP = 8'h00;
    localparam logic [3:0] DCD_UN_MPY_GRP = 4'h5;
    localparam logic [3:0] DCD_N_MPY_SIGNED = 4'h4;
    localparam logic [3:0] DCD_N_MPY_ADD = 4'h0;
    localparam logic [3:0] DCD_N_MPY_SUB = 4'h1;
    localparam logic [3:0] DCD_N_MPY_UNS = 4'h5;
    localparam logic [15:0] DCD_W_PROD_TO_ACC = 16'hbe03;
    localparam logic [15:0] DCD_W_ACC_NEGATE = 16'hbe02;
    localparam logic [15:0] DCD_W_OR_HIGH = 16'hbe82;
    localparam logic [7:0] DCD_UB_NORMALIZE = 8'ha0;
    localparam logic [3:0] DCD_N_OR_SHIFT = 4'hc;
    localparam logic [4:0] DCD_OR_HIGH_SHIFT = 5'h10;

    // ------------------------------------------------------------------
    // lengths and cycle counts
    // ------------------------------------------------------------------
    localparam logic [1:0] DCD_WORDS_1 = 2'h1;
    localparam logic [1:0] DCD_WORDS_2 = 2'h2;
    localparam logic [1:0] DCD_CYC_1 = 2'h1;
    localparam logic [1:0] DCD_CYC_2 = 2'h2;
    localparam logic [1:0] DCD_CYC_3 = 2'h3;

    // ------------------------------------------------------------------
    // decoded control bundle
    // ------------------------------------------------------------------
    typedef struct packed {
        dcd_op_t op;
        logic [1:0] words;
        logic [1:0] cycles;
        logic indirect;
        logic [6:0] addr_field;
        logic [2:0] aux_sel;
        logic [3:0] shift;
        logic [15:0] operand;
    } dcd_ctrl_t;

endpackage

// ### testbench.sv
// self-checking bench for the partial opcode decoder
// assumes dcd_pkg, dcd_decoder, the fetch model and the bound checker
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [15:0] pat;
        logic [15:0] care;
        logic [3:0] wc;
        logic [4:0] fl; // mem, aux hi, aux lo, operand, shift
        dcd_pkg::dcd_op_t op;
    } dcd_tb_ent_t;
    logic clk_sys, rstn, instr_valid, operand_take, ctrl_valid, mem_data_move, illegal_op;
    logic [15:0] instr_word, w1, w2;
    dcd_pkg::dcd_ctrl_t ctrl;
    logic pend, due;
    int fails, comparisons, idx;
    dcd_tb_ent_t tbl [31] = '{
        '{16'hb900, 16'hff00, 4'h5, 5'h08, dcd_pkg::DCD_OP_ACC_IMM},
        '{16'h6a00, 16'hff00, 4'h5, 5'h01, dcd_pkg::DCD_OP_ACC_HIGH},
        '{16'h6900, 16'hff00, 4'h5, 5'h01, dcd_pkg::DCD_OP_ACC_LOW},
        '{16'h6b00, 16'hff00, 4'h5, 5'h01, dcd_pkg::DCD_OP_ACC_TSHIFT},
        '{16'h0000, 16'hf800, 4'h6, 5'h03, dcd_pkg::DCD_OP_AUX_MEM},
        '{16'hb000, 16'hf800, 4'h6, 5'h0a, dcd_pkg::DCD_OP_AUX_SHORT},
        '{16'hbf08, 16'hfff8, 4'ha, 5'h0c, dcd_pkg::DCD_OP_AUX_LONG},
        '{16'hbfc0, 16'hfff0, 4'ha, 5'h18, dcd_pkg::DCD_OP_OR_SHIFT},
        '{16'h0d00, 16'hff00, 4'h6, 5'h01, dcd_pkg::DCD_OP_PAGE_MEM},
        '{16'hbc00, 16'hfe00, 4'h6, 5'h08, dcd_pkg::DCD_OP_PAGE_IMM},
        '{16'h0e00, 16'hff00, 4'h6, 5'h01, dcd_pkg::DCD_OP_STATUS0},
        '{16'h0f00, 16'hff00, 4'h6, 5'h01, dcd_pkg::DCD_OP_STATUS1},
        '{16'h7300, 16'hff00, 4'h5, 5'h01, dcd_pkg::DCD_OP_T_LOAD},
        '{16'h7000, 16'hff00, 4'h5, 5'h01, dcd_pkg::DCD_OP_T_ACCUM},
        '{16'h7200, 16'hff00, 4'h5, 5'h01, dcd_pkg::DCD_OP_T_MOVE},
        '{16'h7100, 16'hff00, 4'h5, 5'h01, dcd_pkg::DCD_OP_T_PRODUCT},
        '{16'h7400, 16'hff00, 4'h5, 5'h01, dcd_pkg::DCD_OP_T_SUBTRACT},
        '{16'ha200, 16'hff00, 4'hb, 5'h09, dcd_pkg::DCD_OP_MAC},
        '{16'ha300, 16'hff00, 4'hb, 5'h09, dcd_pkg::DCD_OP_MAC_MOVE},
        '{16'h8b88, 16'hfff8, 4'h5, 5'h04, dcd_pkg::DCD_OP_AUX_PTR},
        '{16'h8b00, 16'hffff, 4'h5, 5'h00, dcd_pkg::DCD_OP_NOP},
        '{16'h8b00, 16'hff00, 4'h5, 5'h01, dcd_pkg::DCD_OP_AUX_MODIFY},
        '{16'h5400, 16'hff00, 4'h5, 5'h01, dcd_pkg::DCD_OP_MPY_SIGNED},
        '{16'h5000, 16'hff00, 4'h5, 5'h01, dcd_pkg::DCD_OP_MPY_ADD},
        '{16'h5100, 16'hff00, 4'h5, 5'h01, dcd_pkg::DCD_OP_MPY_SUB},
        '{16'h5500, 16'hff00, 4'h5, 5'h01, dcd_pkg::DCD_OP_MPY_UNS},
        '{16'hbe03, 16'hffff, 4'h5, 5'h00, dcd_pkg::DCD_OP_PROD_TO_ACC},
        '{16'hbe02, 16'hffff, 4'h5, 5'h00, dcd_pkg::DCD_OP_ACC_NEGATE},
        '{16'hbe82, 16'hffff, 4'ha, 5'h08, dcd_pkg::DCD_OP_OR_HIGH},
        '{16'ha000, 16'hff00, 4'h5, 5'h01, dcd_pkg::DCD_OP_NORMALIZE},
        '{16'hffff, 16'h0000, 4'h0, 5'h00, dcd_pkg::DCD_OP_NONE}};

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    dcd_fetch_model u_dcd_fetch_model (.clk_sys(clk_sys), .instr_valid(instr_valid),
        .instr_word(instr_word));
    dcd_decoder u_dcd_decoder (.clk_sys(clk_sys), .rstn(rstn), .instr_valid(instr_valid),
        .instr_word(instr_word), .operand_take(operand_take), .ctrl_valid(ctrl_valid),
        .ctrl(ctrl), .mem_data_move(mem_data_move), .illegal_op(illegal_op));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // first matching entry; the catch-all last entry marks unknown words
    function automatic int find(input logic [15:0] w);
        find = 30;
        for (int i = 29; i >= 0; i--) if ((w & tbl[i].care) === tbl[i].pat) find = i;
    endfunction
    task automatic resp(input logic [15:0] w, input logic [15:0] v);
        dcd_tb_ent_t t;
        logic [39:0] e, m;
        logic [15:0] opd;
        t = tbl[find(w)];
        check(64'({ctrl_valid, illegal_op}), 64'({t.wc != 4'h0, t.wc == 4'h0}));
        if (t.wc != 4'h0) begin
            opd = t.wc[3] ? v : {7'h00, w[8:0] & {t.op == dcd_pkg::DCD_OP_PAGE_IMM, 8'hff}};
            e = {t.op, t.wc, w[7:0], t.fl[1] ? w[10:8] : w[2:0], w[3:0], opd};
            m = {9'h1ff, {8{t.fl[0]}}, {3{t.fl[1] | t.fl[2]}}, {4{t.fl[4]}}, {16{t.fl[3]}}};
            check(64'(ctrl[39:31]), 64'(e[39:31]));
            check(64'(ctrl & m), 64'(e & m));
            check(64'(mem_data_move), 64'(t.op inside {dcd_pkg::DCD_OP_T_MOVE,
                dcd_pkg::DCD_OP_MAC_MOVE}));
        end
    endtask

    always @(posedge clk_sys) begin
        if (!rstn) begin
            pend = 1'b0;
            due = 1'b0;
            check(64'({operand_take, ctrl_valid, illegal_op, mem_data_move, ctrl}), 64'h0);
        end else begin
            if (due) resp(w1, w2);
            else check(64'({ctrl_valid, illegal_op}), 64'h0);
            due = 1'b0;
            if (instr_valid === 1'b1) begin
                check(64'(operand_take), 64'(pend));
                if (pend) w2 = instr_word;
                else w1 = instr_word;
                due = pend || !tbl[find(instr_word)].wc[3];
                pend = !pend && tbl[find(instr_word)].wc[3];
            end
        end
    end

    task automatic tally_and_finish();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        fails++;
        tally_and_finish();
    end
    initial begin
        fails = 0;
        comparisons = 0;
        rstn = 1'b1;
        // falling edge after time zero so the async reset is seen
        #1;
        rstn = 1'b0;
        void'($urandom(10));
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        // every table code once, operand after each two-word code
        for (int i = 0; i < 31; i++) begin
            u_dcd_fetch_model.put(tbl[i].pat | (16'($urandom) & ~tbl[i].care));
            if (tbl[i].wc[3]) u_dcd_fetch_model.put(16'($urandom));
        end
        $display("table test done");
        foreach (w1[i]) if (i < 4) u_dcd_fetch_model.put(i[0] ? 16'h7512 : 16'h5299);
        u_dcd_fetch_model.put(16'hb900);
        // gap between first and second word of a long aux load
        u_dcd_fetch_model.put(16'hbf09);
        u_dcd_fetch_model.idle(1 + int'($urandom % 4));
        u_dcd_fetch_model.put(16'($urandom));
        u_dcd_fetch_model.idle(1 + int'($urandom % 4));
        $display("corner test done");
        // pending first word is dropped by a reset
        u_dcd_fetch_model.put(16'hbfc0 | 16'($urandom % 16));
        u_dcd_fetch_model.idle(1 + int'($urandom % 4));
        rstn <= 1'b0;
        u_dcd_fetch_model.idle(1 + int'($urandom % 4));
        rstn <= 1'b1;
        u_dcd_fetch_model.put(16'hb900 | 16'($urandom % 256));
        $display("reset test done");
        repeat (400) begin
            idx = int'($urandom % 31);
            if ($urandom % 8 == 0) u_dcd_fetch_model.put(16'($urandom));
            else u_dcd_fetch_model.put(tbl[idx].pat | (16'($urandom) & ~tbl[idx].care));
            if ($urandom % 4 == 0) u_dcd_fetch_model.idle(1 + int'($urandom % 2));
        end
        u_dcd_fetch_model.idle(4);
        $display("random test done");
        tally_and_finish();
    end
endmodule
